// ===== logic/cfgsp_consts.svh
// Register indices, reset values and field masks of the configuration space
// Overview of operation
// (R01) Index decoded on all eight bits
// (R02) Unimplemented registers ignore writes, read zero
// (R03) Index then data access, config mode only
// (R04) Global registers occupy indices 0x00 to 0x2F
// (R05) Index 0x02 bit 0 soft reset, self-clearing
// (R06) Soft reset loads soft values, others keep
// (R07) Control and select clear on power/hard reset
// (R08) Index-address defaults 0x03, bit 7 reads one
// (R09) Select register at 0x07 picks device bank
// (R10) Activate touches only the selected device
// (R11) Index 0x20 read-only identification code
// (R12) Index 0x21 read-only silicon revision
// (R13) Power control: bits 0,3,4,5, default zero
// (R14) Power management: same bits, 6-7 read zero
// (R15) Power registers clear on power/hard reset
// (R16) Watchdog control bit 0 survives hard reset
// (R17) Watchdog control mixes read-only, write-only bits
// (R18) Activate bit 0 enables selected device only
// (R19) Index port captures, data port accesses register
`ifndef CFGSP_CONSTS_SVH
`define CFGSP_CONSTS_SVH
`define CFGSP_IDX_CFG_CTRL    8'h02
`define CFGSP_IDX_INDEX_ADDR  8'h03
`define CFGSP_IDX_LDN         8'h07
`define CFGSP_IDX_DEV_ID      8'h20
`define CFGSP_IDX_DEV_REV     8'h21
`define CFGSP_IDX_PWR_CTRL    8'h22
`define CFGSP_IDX_PWR_MGMT    8'h23
`define CFGSP_IDX_GLOBAL_LAST 8'h2F
`define CFGSP_IDX_ACTIVATE    8'h30
`define CFGSP_IDX_KBD_IRQ1    8'h70
`define CFGSP_IDX_KBD_IRQ2    8'h72
`define CFGSP_IDX_KBD_GATE    8'hF0
`define CFGSP_IDX_SMI_EN1     8'hB4
`define CFGSP_IDX_SMI_EN2     8'hB5
`define CFGSP_IDX_SMI_ST1     8'hB6
`define CFGSP_IDX_SMI_ST2     8'hB7
`define CFGSP_IDX_PIN_MUX     8'hC0
`define CFGSP_IDX_FORCE_DISK  8'hC1
`define CFGSP_IDX_FLOPPY_SHD  8'hC2
`define CFGSP_IDX_UART1_SHD   8'hC3
`define CFGSP_IDX_UART2_SHD   8'hC4
`define CFGSP_IDX_WAKE_CTRL   8'hC5
`define CFGSP_IDX_WAKE_ST     8'hC6
`define CFGSP_IDX_WAKE_SRC_ST 8'hC7
`define CFGSP_IDX_WAKE_SRC_EN 8'hC8
`define CFGSP_IDX_WDT_TIMEOUT 8'hF1
`define CFGSP_IDX_WATCHDOG_COUNT_VALUE     8'hF2
`define CFGSP_IDX_WATCHDOG_SETUP     8'hF3
`define CFGSP_IDX_WATCHDOG_CONTROL    8'hF4
`define CFGSP_LDN_KBD         8'h07
`define CFGSP_LDN_AUX         8'h08
`define CFGSP_PWR_MASK        8'h39
`define CFGSP_RST_INDEX_ADDR  7'h03
`define CFGSP_RST_PIN_MUX     8'h02
`define CFGSP_RST_FORCE_DISK  8'h01
`define CFGSP_SOFT_RST_BIT    0
`define CFGSP_WDT_FORCE_BIT   1
`endif

// ===== logic/cfgsp_pkg.sv
// Types shared by the configuration space block
package cfgsp_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       data_sel;
        logic [7:0] wdata;
    } cfgsp_req_s;

    typedef struct packed {
        logic [7:0] ldn;
        logic [7:0] pwr_ctrl;
        logic [7:0] pwr_mgmt;
        logic       kbd_act;
        logic [7:0] kbd_irq1;
        logic [7:0] kbd_irq2;
        logic [7:0] kbd_gate_sel;
        logic       aux_act;
        logic [7:0] smi_en1;
        logic [7:0] smi_en2;
        logic [7:0] smi_st1;
        logic [7:0] smi_st2;
        logic [7:0] pin_mux;
        logic [7:0] force_disk;
        logic [7:0] wake_ctrl;
        logic [7:0] wake_st;
        logic [7:0] wake_src_st;
        logic [7:0] wake_src_en;
        logic [7:0] wdt_timeout;
        logic [7:0] watchdog_count_value;
        logic [7:0] watchdog_setup;
        logic       wdt_enable;
    } cfgsp_cfg_s;

    typedef struct packed {
        cfgsp_cfg_s cfg;
        logic [7:0] index;
        logic [6:0] index_addr;
        logic [7:0] rd_data;
        logic       rd_valid;
        logic       soft_rst;
        logic       wdt_force;
    } cfgsp_state_s;
endpackage : cfgsp_pkg

// ===== logic/cfgsp_regs.sv
// Indexed configuration register space: global and keyboard/aux device banks
`timescale 1ns/1ps
`include "cfgsp_consts.svh"

module cfgsp_regs #(
    parameter logic [7:0] DEVICE_IDENTIFICATION  = 8'hA5,  // Arbitrary value
    parameter logic [7:0] DEVICE_REV = 8'h01   // Arbitrary value
) (
    // Clock and resets
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  hard_reset,
    input  wire logic                  main_power_on_reset,
    // Host index/data ports
    input  wire logic                  cfg_mode,
    input  wire cfgsp_pkg::cfgsp_req_s host_req,
    output      logic [7:0]            rd_data_q,
    output      logic                  rd_valid_q,
    // Status from the functions
    input  wire logic [7:0]            floppy_rate_shadow,
    input  wire logic [7:0]            uart_one_fifo_shadow,
    input  wire logic [7:0]            uart_two_fifo_shadow,
    input  wire logic [5:0]            wdt_status,
    input  wire logic [7:0]            wake_event_set,
    input  wire logic [7:0]            wake_source_set,
    // Configuration to the functions
    output      cfgsp_pkg::cfgsp_cfg_s cfg_q,
    output      logic                  soft_reset_pulse_q,
    output      logic                  wdt_force_pulse_q
);

    cfgsp_pkg::cfgsp_state_s st_q;
    cfgsp_pkg::cfgsp_state_s st_d;
    logic [7:0]              rdv;
    logic                    sel_kbd;
    logic                    sel_aux;
    logic                    is_global;
    logic                    data_rd;
    logic                    data_wr;

    assign rd_data_q          = st_q.rd_data;
    assign rd_valid_q         = st_q.rd_valid;
    assign cfg_q              = st_q.cfg;
    assign soft_reset_pulse_q = st_q.soft_rst;
    assign wdt_force_pulse_q  = st_q.wdt_force;

    always_comb begin
        st_d           = st_q;
        st_d.rd_valid  = 1'b0;
        st_d.soft_rst  = 1'b0;
        st_d.wdt_force = 1'b0;
        rdv            = 8'h00;
        is_global      = (st_q.index <= `CFGSP_IDX_GLOBAL_LAST);            // [R04]
        sel_kbd        = (st_q.cfg.ldn == `CFGSP_LDN_KBD);                  // [R09]
        sel_aux        = (st_q.cfg.ldn == `CFGSP_LDN_AUX);                  // [R09]
        data_rd        = host_req.rd && host_req.data_sel && cfg_mode;     // [R03]
        data_wr        = host_req.wr && host_req.data_sel && cfg_mode;     // [R03]

        // Read decode; unmatched indices fall through to zero
        if (is_global) begin
            if (st_q.index == `CFGSP_IDX_INDEX_ADDR) begin
                rdv = {1'b1, st_q.index_addr};                              // [R08]
            end else if (st_q.index == `CFGSP_IDX_LDN) begin
                rdv = st_q.cfg.ldn;
            end else if (st_q.index == `CFGSP_IDX_DEV_ID) begin
                rdv = DEVICE_IDENTIFICATION;                                            // [R11]
            end else if (st_q.index == `CFGSP_IDX_DEV_REV) begin
                rdv = DEVICE_REV;                                           // [R12]
            end else if (st_q.index == `CFGSP_IDX_PWR_CTRL) begin
                rdv = st_q.cfg.pwr_ctrl;
            end else if (st_q.index == `CFGSP_IDX_PWR_MGMT) begin
                rdv = st_q.cfg.pwr_mgmt;
            end else begin
                rdv = 8'h00;                                                // [R02]
            end
        end else if (sel_kbd) begin
            if (st_q.index == `CFGSP_IDX_ACTIVATE) begin
                rdv = {7'h00, st_q.cfg.kbd_act};                            // [R18]
            end else if (st_q.index == `CFGSP_IDX_KBD_IRQ1) begin
                rdv = st_q.cfg.kbd_irq1;
            end else if (st_q.index == `CFGSP_IDX_KBD_IRQ2) begin
                rdv = st_q.cfg.kbd_irq2;
            end else if (st_q.index == `CFGSP_IDX_KBD_GATE) begin
                rdv = st_q.cfg.kbd_gate_sel;
            end else begin
                rdv = 8'h00;                                                // [R02]
            end
        end else if (sel_aux) begin
            if (st_q.index == `CFGSP_IDX_ACTIVATE) begin
                rdv = {7'h00, st_q.cfg.aux_act};                            // [R18]
            end else if (st_q.index == `CFGSP_IDX_SMI_EN1) begin
                rdv = st_q.cfg.smi_en1;
            end else if (st_q.index == `CFGSP_IDX_SMI_EN2) begin
                rdv = st_q.cfg.smi_en2;
            end else if (st_q.index == `CFGSP_IDX_SMI_ST1) begin
                rdv = st_q.cfg.smi_st1;
            end else if (st_q.index == `CFGSP_IDX_SMI_ST2) begin
                rdv = st_q.cfg.smi_st2;
            end else if (st_q.index == `CFGSP_IDX_PIN_MUX) begin
                rdv = st_q.cfg.pin_mux;
            end else if (st_q.index == `CFGSP_IDX_FORCE_DISK) begin
                rdv = st_q.cfg.force_disk;
            end else if (st_q.index == `CFGSP_IDX_FLOPPY_SHD) begin
                rdv = floppy_rate_shadow;
            end else if (st_q.index == `CFGSP_IDX_UART1_SHD) begin
                rdv = uart_one_fifo_shadow;
            end else if (st_q.index == `CFGSP_IDX_UART2_SHD) begin
                rdv = uart_two_fifo_shadow;
            end else if (st_q.index == `CFGSP_IDX_WAKE_CTRL) begin
                rdv = st_q.cfg.wake_ctrl;
            end else if (st_q.index == `CFGSP_IDX_WAKE_ST) begin
                rdv = st_q.cfg.wake_st;
            end else if (st_q.index == `CFGSP_IDX_WAKE_SRC_ST) begin
                rdv = st_q.cfg.wake_src_st;
            end else if (st_q.index == `CFGSP_IDX_WAKE_SRC_EN) begin
                rdv = st_q.cfg.wake_src_en;
            end else if (st_q.index == `CFGSP_IDX_WDT_TIMEOUT) begin
                rdv = st_q.cfg.wdt_timeout;
            end else if (st_q.index == `CFGSP_IDX_WATCHDOG_COUNT_VALUE) begin
                rdv = st_q.cfg.watchdog_count_value;
            end else if (st_q.index == `CFGSP_IDX_WATCHDOG_SETUP) begin
                rdv = st_q.cfg.watchdog_setup;
            end else if (st_q.index == `CFGSP_IDX_WATCHDOG_CONTROL) begin
                // Force bit is write-only and reads back zero
                rdv = {wdt_status, 1'b0, st_q.cfg.wdt_enable};              // [R17]
            end else begin
                rdv = 8'h00;                                                // [R02]
            end
        end else begin
            rdv = 8'h00;                                                    // [R02]
        end

        if (host_req.rd && cfg_mode) begin
            st_d.rd_data  = host_req.data_sel ? rdv : st_q.index;           // [R19]
            st_d.rd_valid = 1'b1;
        end

        // Index port holds all eight bits so no aliasing can occur
        if (host_req.wr && !host_req.data_sel && cfg_mode) begin
            st_d.index = host_req.wdata;                                    // [R01] [R19]
        end

        if (data_wr) begin
            if (is_global) begin
                if (st_q.index == `CFGSP_IDX_CFG_CTRL) begin
                    st_d.soft_rst = host_req.wdata[`CFGSP_SOFT_RST_BIT];    // [R05]
                end else if (st_q.index == `CFGSP_IDX_INDEX_ADDR) begin
                    st_d.index_addr = host_req.wdata[6:0];                  // [R08]
                end else if (st_q.index == `CFGSP_IDX_LDN) begin
                    st_d.cfg.ldn = host_req.wdata;                          // [R09]
                end else if (st_q.index == `CFGSP_IDX_PWR_CTRL) begin
                    st_d.cfg.pwr_ctrl = host_req.wdata & `CFGSP_PWR_MASK;   // [R13]
                end else if (st_q.index == `CFGSP_IDX_PWR_MGMT) begin
                    st_d.cfg.pwr_mgmt = host_req.wdata & `CFGSP_PWR_MASK;   // [R14]
                end
            end else if (sel_kbd) begin
                if (st_q.index == `CFGSP_IDX_ACTIVATE) begin
                    st_d.cfg.kbd_act = host_req.wdata[0];                   // [R10] [R18]
                end else if (st_q.index == `CFGSP_IDX_KBD_IRQ1) begin
                    st_d.cfg.kbd_irq1 = host_req.wdata;
                end else if (st_q.index == `CFGSP_IDX_KBD_IRQ2) begin
                    st_d.cfg.kbd_irq2 = host_req.wdata;
                end else if (st_q.index == `CFGSP_IDX_KBD_GATE) begin
                    st_d.cfg.kbd_gate_sel = host_req.wdata;
                end
            end else if (sel_aux) begin
                if (st_q.index == `CFGSP_IDX_ACTIVATE) begin
                    st_d.cfg.aux_act = host_req.wdata[0];                   // [R10] [R18]
                end else if (st_q.index == `CFGSP_IDX_SMI_EN1) begin
                    st_d.cfg.smi_en1 = host_req.wdata;
                end else if (st_q.index == `CFGSP_IDX_SMI_EN2) begin
                    st_d.cfg.smi_en2 = host_req.wdata;
                end else if (st_q.index == `CFGSP_IDX_SMI_ST1) begin
                    st_d.cfg.smi_st1 = host_req.wdata;
                end else if (st_q.index == `CFGSP_IDX_SMI_ST2) begin
                    st_d.cfg.smi_st2 = host_req.wdata;
                end else if (st_q.index == `CFGSP_IDX_PIN_MUX) begin
                    st_d.cfg.pin_mux = host_req.wdata;
                end else if (st_q.index == `CFGSP_IDX_FORCE_DISK) begin
                    st_d.cfg.force_disk = host_req.wdata;
                end else if (st_q.index == `CFGSP_IDX_WAKE_CTRL) begin
                    st_d.cfg.wake_ctrl = host_req.wdata;
                end else if (st_q.index == `CFGSP_IDX_WAKE_ST) begin
                    st_d.cfg.wake_st = st_q.cfg.wake_st & ~host_req.wdata;
                end else if (st_q.index == `CFGSP_IDX_WAKE_SRC_ST) begin
                    st_d.cfg.wake_src_st = st_q.cfg.wake_src_st & ~host_req.wdata;
                end else if (st_q.index == `CFGSP_IDX_WAKE_SRC_EN) begin
                    st_d.cfg.wake_src_en = host_req.wdata;
                end else if (st_q.index == `CFGSP_IDX_WDT_TIMEOUT) begin
                    st_d.cfg.wdt_timeout = host_req.wdata;
                end else if (st_q.index == `CFGSP_IDX_WATCHDOG_COUNT_VALUE) begin
                    st_d.cfg.watchdog_count_value = host_req.wdata;
                end else if (st_q.index == `CFGSP_IDX_WATCHDOG_SETUP) begin
                    st_d.cfg.watchdog_setup = host_req.wdata;
                end else if (st_q.index == `CFGSP_IDX_WATCHDOG_CONTROL) begin
                    st_d.cfg.wdt_enable = host_req.wdata[0];                // [R17]
                    st_d.wdt_force = host_req.wdata[`CFGSP_WDT_FORCE_BIT];  // [R17]
                end
            end
        end

        // Events set after the clear so a same-cycle event is not lost
        st_d.cfg.wake_st     = st_d.cfg.wake_st | wake_event_set;
        st_d.cfg.wake_src_st = st_d.cfg.wake_src_st | wake_source_set;

        // Soft reset: only registers that carry a soft value are loaded
        if (st_d.soft_rst) begin
            st_d.cfg.kbd_act  = 1'b0;                                       // [R06]
            st_d.cfg.kbd_irq1 = 8'h00;                                      // [R06]
            st_d.cfg.kbd_irq2 = 8'h00;                                      // [R06]
            st_d.cfg.aux_act  = 1'b0;                                       // [R06]
        end

        // Main-supply and hard reset; wake registers only follow reset
        if (hard_reset || main_power_on_reset) begin
            st_d.soft_rst          = 1'b0;
            st_d.wdt_force         = 1'b0;
            st_d.index_addr        = `CFGSP_RST_INDEX_ADDR;                 // [R08]
            st_d.cfg.ldn           = 8'h00;                                 // [R07]
            st_d.cfg.pwr_ctrl      = 8'h00;                                 // [R15]
            st_d.cfg.pwr_mgmt      = 8'h00;                                 // [R15]
            st_d.cfg.kbd_act       = 1'b0;
            st_d.cfg.kbd_irq1      = 8'h00;
            st_d.cfg.kbd_irq2      = 8'h00;
            st_d.cfg.kbd_gate_sel  = 8'h00;
            st_d.cfg.aux_act       = 1'b0;
            st_d.cfg.pin_mux       = `CFGSP_RST_PIN_MUX;
            st_d.cfg.force_disk    = `CFGSP_RST_FORCE_DISK;
            st_d.cfg.wdt_timeout   = 8'h00;
            st_d.cfg.watchdog_count_value       = 8'h00;
            st_d.cfg.watchdog_setup       = 8'h00;
        end
        if (main_power_on_reset) begin
            st_d.cfg.smi_en1    = 8'h00;
            st_d.cfg.smi_en2    = 8'h00;
            st_d.cfg.smi_st1    = 8'h00;
            st_d.cfg.smi_st2    = 8'h00;
            st_d.cfg.wdt_enable = 1'b0;                                     // [R16]
        end
    end

    // Async reset is the standby-supply power-on reset: everything to default
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q                <= '0;
            st_q.index_addr     <= `CFGSP_RST_INDEX_ADDR;                   // [R08]
            st_q.cfg.pin_mux    <= `CFGSP_RST_PIN_MUX;
            st_q.cfg.force_disk <= `CFGSP_RST_FORCE_DISK;
        end else begin
            st_q <= st_d;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic quiet;
    assign quiet = !hard_reset && !main_power_on_reset;

    a_full_index_decode: assert property (                                  // [R01]
        (data_wr && st_q.index == 8'h82 && host_req.wdata[0]) |=> !st_q.soft_rst)
        else $error("Aliased index triggered a soft reset");
    a_unmapped_reads_zero: assert property (                                // [R02]
        (data_rd && st_q.index >= 8'h08 && st_q.index <= 8'h1F)
        |=> (st_q.rd_valid && st_q.rd_data == 8'h00))
        else $error("Reserved global index read nonzero");
    a_config_mode_gate: assert property (                                   // [R03]
        (host_req.wr && !cfg_mode && quiet) |=> ($stable(st_q.index) && $stable(st_q.cfg.ldn)))
        else $error("Write outside configuration mode took effect");
    a_soft_reset_pulse: assert property (                                   // [R05]
        (data_wr && quiet && st_q.index == `CFGSP_IDX_CFG_CTRL && host_req.wdata[0])
        |=> st_q.soft_rst ##1 !st_q.soft_rst)
        else $error("Soft reset bit did not self-clear after one cycle");
    a_soft_reset_values: assert property (                                  // [R06]
        st_q.soft_rst |-> (!st_q.cfg.kbd_act && !st_q.cfg.aux_act && st_q.cfg.kbd_irq1 == 8'h00))
        else $error("Soft reset did not load soft values");
    a_hard_reset_select: assert property (                                  // [R07] [R15]
        hard_reset |=> (st_q.cfg.ldn == 8'h00 && st_q.cfg.pwr_ctrl == 8'h00
                        && st_q.cfg.pwr_mgmt == 8'h00))
        else $error("Select or power register not cleared by hard reset");
    a_index_addr_bit7: assert property (                                    // [R08]
        (data_rd && st_q.index == `CFGSP_IDX_INDEX_ADDR) |=> st_q.rd_data[7])
        else $error("Index-address bit 7 read as zero");
    a_activate_isolated: assert property (                                  // [R10]
        (data_wr && quiet && sel_kbd && st_q.index == `CFGSP_IDX_ACTIVATE && !st_d.soft_rst)
        |=> ($stable(st_q.cfg.aux_act) && st_q.cfg.kbd_act == $past(host_req.wdata[0])))
        else $error("Activate write reached an unselected device");
    a_device_identification_read: assert property (                                     // [R11]
        (data_rd && st_q.index == `CFGSP_IDX_DEV_ID) |=> st_q.rd_data == DEVICE_IDENTIFICATION)
        else $error("Identification read returned wrong value");
    a_power_reserved: assert property (                                     // [R13] [R14]
        ((st_q.cfg.pwr_ctrl | st_q.cfg.pwr_mgmt) & ~`CFGSP_PWR_MASK) == 8'h00)
        else $error("Reserved power bit set");
    a_wdt_bit0_kept: assert property (                                      // [R16]
        (hard_reset && !main_power_on_reset) |=> $stable(st_q.cfg.wdt_enable))
        else $error("Watchdog bit 0 lost on hard reset");

    c_soft_reset: cover property (st_q.soft_rst);
    c_aux_activate: cover property (st_q.cfg.aux_act && sel_aux);
    c_wake_clear: cover property (data_wr && sel_aux && st_q.index == `CFGSP_IDX_WAKE_ST);
    c_id_read: cover property (data_rd && st_q.index == `CFGSP_IDX_DEV_ID);

endmodule : cfgsp_regs

// ===== sim/cfgsp_host.sv
// Host model driving the index and data ports
`timescale 1ns/1ps
module cfgsp_host (
    // Clock
    input  wire logic                  clk,
    // Ports toward the block
    output      logic                  cfg_mode,
    output      cfgsp_pkg::cfgsp_req_s host_req,
    input  wire logic [7:0]            rd_data_q,
    input  wire logic                  rd_valid_q
);
    initial begin
        cfg_mode = 1'b1;
        host_req = '0;
    end

    task set_mode(input logic m);
        @(posedge clk);
        cfg_mode <= m;
    endtask : set_mode

    // Released data bus shows the inverse, so stale bytes never pass
    task xfer(input logic rd, input logic sel, input logic [7:0] d,
              output logic [7:0] q, output logic ok);
        @(posedge clk);
        host_req <= '{wr: !rd, rd: rd, data_sel: sel, wdata: d};
        @(posedge clk);
        host_req <= '{wr: 1'b0, rd: 1'b0, data_sel: sel, wdata: ~d};
        @(posedge clk);
        ok = rd_valid_q;
        q = rd_data_q;
    endtask : xfer
endmodule : cfgsp_host

// ===== sim/config_register_space_bench.sv
// Self-checking bench for the configuration register space
`timescale 1ns/1ps
`include "cfgsp_consts.svh"
module config_register_space_bench;
    localparam logic [7:0] ID  = 8'h5A; // Arbitrary value
    localparam logic [7:0] REV = 8'h03; // Arbitrary value
    logic       clk = 1'b0, reset = 1'b1, hard_reset = 1'b0, main_power_on_reset = 1'b0;
    logic [5:0] wdt_status = 6'h2A;
    logic [7:0] wake_set   = 8'h00;
    logic       cfg_mode, rd_valid_q, soft_reset_pulse_q, wdt_force_pulse_q, ok;
    logic [7:0] rd_data_q, q;
    logic [7:0] rsv [5] = '{8'h00, 8'h01, 8'h05, 8'h1F, 8'h28};
    int         fail_count = 0, tests_run = 0;
    cfgsp_pkg::cfgsp_req_s host_req;
    cfgsp_pkg::cfgsp_cfg_s cfg_q;

    cfgsp_regs #(.DEVICE_IDENTIFICATION(ID), .DEVICE_REV(REV)) i_dut (.clk(clk), .reset(reset),
        .hard_reset(hard_reset), .main_power_on_reset(main_power_on_reset),
        .cfg_mode(cfg_mode), .host_req(host_req), .rd_data_q(rd_data_q),
        .rd_valid_q(rd_valid_q), .floppy_rate_shadow(8'h00), .uart_one_fifo_shadow(8'h00),
        .uart_two_fifo_shadow(8'h00), .wdt_status(wdt_status), .wake_event_set(wake_set),
        .wake_source_set(wake_set), .cfg_q(cfg_q), .soft_reset_pulse_q(soft_reset_pulse_q),
        .wdt_force_pulse_q(wdt_force_pulse_q));
    cfgsp_host i_host (.clk(clk), .cfg_mode(cfg_mode), .host_req(host_req),
        .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));

    initial begin
        forever #50 clk = ~clk;
    end

    task check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task wr(input logic [7:0] idx, input logic [7:0] v);
        i_host.xfer(1'b0, 1'b0, idx, q, ok);
        i_host.xfer(1'b0, 1'b1, v, q, ok);
    endtask : wr

    task rd(input logic [7:0] idx, input logic [7:0] exp);
        i_host.xfer(1'b0, 1'b0, idx, q, ok);
        i_host.xfer(1'b1, 1'b1, 8'h00, q, ok);
        check({7'h00, ok}, 8'h01);
        check(q, exp);
    endtask : rd

    // Synchronous reset inputs held for one edge
    task pulse(input logic main_supply);
        @(posedge clk);
        hard_reset <= !main_supply;
        main_power_on_reset <= main_supply;
        @(posedge clk);
        hard_reset <= 1'b0;
        main_power_on_reset <= 1'b0;
    endtask : pulse

    task end_sim;
        if (fail_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    // About 325 cycles expected; six times that means a hang
    initial begin
        #200000;
        fail_count++;
        end_sim();
    end

    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rd(`CFGSP_IDX_INDEX_ADDR, 8'h83);
        rd(`CFGSP_IDX_LDN, 8'h00);
        wr(`CFGSP_IDX_DEV_ID, 8'hFF);
        rd(`CFGSP_IDX_DEV_ID, ID);
        rd(`CFGSP_IDX_DEV_REV, REV);
        foreach (rsv[i]) begin
            wr(rsv[i], 8'hFF);
            rd(rsv[i], 8'h00);
        end
        wr(`CFGSP_IDX_PWR_CTRL, 8'hFF);
        rd(`CFGSP_IDX_PWR_CTRL, 8'h39);
        wr(`CFGSP_IDX_PWR_MGMT, 8'hFF);
        rd(`CFGSP_IDX_PWR_MGMT, 8'h39);
        wr(8'hA2, 8'h00);
        rd(`CFGSP_IDX_PWR_CTRL, 8'h39);
        wr(8'h82, 8'h01);
        check({7'h00, soft_reset_pulse_q}, 8'h00);
        wr(`CFGSP_IDX_LDN, `CFGSP_LDN_KBD);
        wr(`CFGSP_IDX_ACTIVATE, 8'hFF);
        wr(`CFGSP_IDX_KBD_IRQ1, 8'h5A);
        rd(`CFGSP_IDX_ACTIVATE, 8'h01);
        wr(`CFGSP_IDX_LDN, `CFGSP_LDN_AUX);
        rd(`CFGSP_IDX_ACTIVATE, 8'h00);
        rd(`CFGSP_IDX_PIN_MUX, `CFGSP_RST_PIN_MUX);
        check(cfg_q.force_disk, `CFGSP_RST_FORCE_DISK);
        // One-cycle event pulse into both wake status registers
        wake_set <= 8'h81;
        @(posedge clk);
        wake_set <= 8'h00;
        rd(`CFGSP_IDX_WAKE_SRC_ST, 8'h81);
        wr(`CFGSP_IDX_WAKE_ST, 8'h01);
        rd(`CFGSP_IDX_WAKE_ST, 8'h80);
        wr(`CFGSP_IDX_WATCHDOG_CONTROL, 8'h03);
        check({7'h00, wdt_force_pulse_q}, 8'h01);
        rd(`CFGSP_IDX_WATCHDOG_CONTROL, {wdt_status, 2'b01});
        wr(`CFGSP_IDX_LDN, `CFGSP_LDN_KBD);
        rd(`CFGSP_IDX_KBD_IRQ1, 8'h5A);
        check(cfg_q.kbd_irq1, 8'h5A);
        wr(`CFGSP_IDX_CFG_CTRL, 8'h01);
        check({7'h00, soft_reset_pulse_q}, 8'h01);
        rd(`CFGSP_IDX_CFG_CTRL, 8'h00);
        rd(`CFGSP_IDX_ACTIVATE, 8'h00);
        rd(`CFGSP_IDX_KBD_IRQ1, 8'h00);
        rd(`CFGSP_IDX_PWR_CTRL, 8'h39);
        pulse(1'b0);
        rd(`CFGSP_IDX_LDN, 8'h00);
        rd(`CFGSP_IDX_PWR_CTRL, 8'h00);
        rd(`CFGSP_IDX_PWR_MGMT, 8'h00);
        rd(`CFGSP_IDX_INDEX_ADDR, 8'h83);
        wr(`CFGSP_IDX_LDN, `CFGSP_LDN_AUX);
        rd(`CFGSP_IDX_WATCHDOG_CONTROL, {wdt_status, 2'b01});
        pulse(1'b1);
        wr(`CFGSP_IDX_LDN, `CFGSP_LDN_AUX);
        rd(`CFGSP_IDX_WATCHDOG_CONTROL, {wdt_status, 2'b00});
        wr(`CFGSP_IDX_LDN, `CFGSP_LDN_KBD);
        i_host.set_mode(1'b0);
        wr(`CFGSP_IDX_LDN, `CFGSP_LDN_AUX);
        i_host.xfer(1'b1, 1'b1, 8'h00, q, ok);
        check({7'h00, ok}, 8'h00);
        i_host.set_mode(1'b1);
        rd(`CFGSP_IDX_LDN, `CFGSP_LDN_KBD);
        end_sim();
    end
endmodule : config_register_space_bench
